// ===== rtl/pms_loop_mode_supervisor.sv
// loop mode supervisor and setpoint conditioner for up to 16 loops
`timescale 1ns/1ps

// Contract
// R01: following loops in Program mode are forced Manual and not calculated.
// R02: in Run mode each loop's current mode is recorded as desired mode.
// R03: power restored in Run mode returns every loop to its recorded mode.
// R04: Program-to-Run returns each loop to the mode recorded in last Run; the code restores following loops only, independent loops keep their mode.
// R05: new loops are added only in Program mode and start in Manual.
// R06: normally loop mode follows request bits 0 to 2 of first word.
// R07: following loops reject mode requests while controller is in Program.
// R08: major loop Manual-to-Auto refused until its minor loop is Cascade.
// R09: a loop with an error condition is placed in Manual.
// R10: minor loop leaving Cascade switches its major loop to Manual.
// R11: bit 3 of first word picks transfer type, zero I, one II.
// R12: type I position to Auto: bias from output, setpoint from process value.
// R13: type I velocity copies process value; Cascade entry sets major output.
// R14: type II position Manual-to-Auto only sets bias; nothing else.
// R15: configurer must choose type I whenever velocity algorithm is used.
// R16: bits 0 and 1 of second word choose 12/15-bit, uni/bipolar format.
// R17: bit 3 of second word clamps calculation setpoint between limits.
// R18: setpoint limits are re-read before every loop calculation.
// R19: setpoint is local in Manual/Auto, pointer-addressed word in Cascade.
// R20: control program preloads integrator with offset before Manual-to-Auto.
// R21: request bits are cleared after being read.
// R22: actual mode is reported in bits 0 to 2 of status word.
// R23: bit 15 of first word selects follow controller or independent.
// R24: a loop never goes directly from Manual to Cascade.
// R25: bit 0 Manual, 1 Auto, 2 Cascade; multi-bit request just cleared.
module pms_loop_mode_supervisor
#(
  parameter int NLOOPS = 16
)
(
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // loop parameter table access
  input  wire pms_pkg::pms_tbl_req_t tbl_req,
  output pms_pkg::pms_tbl_rsp_t      tbl_rsp,
  // loop sample tick and per-loop error conditions
  input  wire logic                  loop_tick,
  input  wire logic [15:0]           loop_error,
  // controller mode and power restoration, from pins
  input  wire logic                  run_mode_pin,
  input  wire logic                  power_restored_pin,
  // calculation request toward the loop arithmetic
  output pms_pkg::pms_calc_t         calc,
  output logic                       run_active
);
  import pms_pkg::*;

  typedef logic [PMS_MAX_LOOPS-1:0][15:0] pms_words_t;
  typedef logic [PMS_MAX_LOOPS-1:0][2:0]  pms_modes_t;

  typedef struct packed {
    pms_state_t                st;
    logic [3:0]                idx;
    logic                      run_s1;
    logic                      run_s2;
    logic                      run_d;
    logic                      pwr_s1;
    logic                      pwr_s2;
    logic                      pwr_d;
    logic [PMS_MAX_LOOPS-1:0]  cfg;
    pms_modes_t                mode;
    pms_modes_t                desired;
    pms_words_t                mode1;
    pms_words_t                mode2;
    pms_words_t                lsp;
    pms_words_t                pval;
    pms_words_t                integ;
    pms_words_t                cout;
    pms_words_t                splo;
    pms_words_t                sphi;
    pms_words_t                rsp;
    pms_tbl_rsp_t              rsp_out;
    pms_calc_t                 calc_out;
  } pms_regs_t;

  pms_regs_t r;
  pms_regs_t n;

  if (NLOOPS < 1 || NLOOPS > PMS_MAX_LOOPS)
  begin : g_bad_nloops
    $error("NLOOPS must lie between 1 and 16");
  end

  // table word of one loop, as software and the remote pointer see it
  function automatic logic [15:0] tbl_word(input pms_regs_t s,
                                           input logic [3:0] l,
                                           input logic [5:0] o);
    logic [15:0] w;
    w = WORD_RST;
    if (o == OFF_MODE_ONE) w = s.mode1[l];
    else if (o == OFF_MODE_TWO) w = s.mode2[l];
    else if (o == OFF_LOC_SETPT) w = s.lsp[l];
    else if (o == OFF_PROC_VAL) w = s.pval[l];
    else if (o == OFF_INTEG) w = s.integ[l];
    else if (o == OFF_CTRL_OUT) w = s.cout[l];
    else if (o == OFF_STATUS) w = {13'h0000, s.mode[l]}; // R22
    else if (o == OFF_SETPT_LO) w = s.splo[l];
    else if (o == OFF_SETPT_HI) w = s.sphi[l];
    else if (o == OFF_RSP_PTR) w = s.rsp[l];
    return w;
  endfunction : tbl_word

  // value as a signed number under the selected data format
  function automatic logic signed [16:0] fmt_val(input logic [15:0] v,
                                                 input logic [1:0] f);
    logic signed [16:0] x;
    x = signed'({1'b0, v});
    if (f[M2_FMT_BIPOL] && !f[M2_FMT_WIDE])
      x = signed'({{5{v[11]}}, v[11:0]}); // R16
    else if (f[M2_FMT_BIPOL])
      x = signed'({{2{v[14]}}, v[14:0]}); // R16
    else if (!f[M2_FMT_WIDE])
      x = signed'({5'h00, v[11:0]}); // R16
    else
      x = signed'({2'h0, v[14:0]}); // R16
    return x;
  endfunction : fmt_val

  // clamp a setpoint between lower and upper limit
  function automatic logic [15:0] clamp_setp(input logic [15:0] setp,
                                             input logic [15:0] lo,
                                             input logic [15:0] hi,
                                             input logic [1:0] f);
    logic [15:0] c;
    c = setp;
    if (fmt_val(setp, f) < fmt_val(lo, f)) c = lo; // R17
    else if (fmt_val(setp, f) > fmt_val(hi, f)) c = hi; // R17
    return c;
  endfunction : clamp_setp

  // loop index held in a remote setpoint pointer
  function automatic logic [3:0] ptr_loop(input logic [15:0] p);
    return p[PTR_LOOP_LSB +: PMS_IDXW];
  endfunction : ptr_loop

  always_comb
  begin
    logic [3:0]  i;
    logic [3:0]  maj;
    logic [2:0]  cur;
    logic [2:0]  req;
    logic [2:0]  nm;
    logic [1:0]  fmt;
    logic [15:0] setp;
    logic        hold;
    logic        is_major;
    logic        minor_cas;
    logic        type_two;
    logic        vel;
    logic        run_rise;
    logic        run_fall;
    logic        pwr_rise;
    i = r.idx;
    maj = ptr_loop(r.rsp[r.idx]);
    cur = r.mode[r.idx];
    req = r.mode1[r.idx][2:0];
    nm = cur;
    fmt = r.mode2[r.idx][1:0];
    setp = WORD_RST;
    hold = !r.run_s2 && !r.mode1[r.idx][M1_INDEP]; // R23
    is_major = 1'b0;
    minor_cas = 1'b0;
    type_two = r.mode1[r.idx][M1_XFER_TYPE]; // R11
    vel = r.mode1[r.idx][M1_VELOCITY];
    run_rise = r.run_s2 && !r.run_d;
    run_fall = !r.run_s2 && r.run_d;
    pwr_rise = r.pwr_s2 && !r.pwr_d;
    n = r;
    n.run_s1 = run_mode_pin;
    n.run_s2 = r.run_s1;
    n.run_d = r.run_s2;
    n.pwr_s1 = power_restored_pin;
    n.pwr_s2 = r.pwr_s1;
    n.pwr_d = r.pwr_s2;
    n.calc_out.valid = 1'b0;
    n.rsp_out.rvalid = 1'b0;

    // find the minor loop whose setpoint pointer names this loop, if any
    for (int j = 0; j < NLOOPS; j++)
    begin
      if (r.cfg[j] && r.mode2[j][M2_MINOR] && ptr_loop(r.rsp[j]) == i)
      begin
        is_major = 1'b1;
        if (r.mode[j] == MODE_CASCADE)
          minor_cas = 1'b1;
      end
    end

    case (r.st)
      PMS_IDLE:
      begin
        if (loop_tick)
        begin
          n.st = PMS_SCAN;
          n.idx = 4'h0;
        end
      end
      PMS_SCAN:
      begin
        if (r.cfg[i])
        begin
          if (hold)
            nm = MODE_MANUAL; // R01 R07
          else if (req == MODE_MANUAL)
            nm = MODE_MANUAL; // R06 R25
          else if (req == MODE_AUTO)
          begin
            if (!(cur == MODE_MANUAL && is_major && !minor_cas)) // R08
              nm = MODE_AUTO; // R06 R25
          end
          else if (req == MODE_CASCADE)
          begin
            if (cur != MODE_MANUAL) // R24
              nm = MODE_CASCADE; // R06 R25
          end
          if (loop_error[i])
            nm = MODE_MANUAL; // R09
          n.mode1[i][2:0] = REQ_NONE; // R21 R25
          n.mode[i] = nm;
          if (r.run_s2)
            n.desired[i] = nm; // R02
          if (cur == MODE_MANUAL && nm == MODE_AUTO)
          begin
            if (!vel)
              n.integ[i] = r.cout[i]; // R12 R14
            if (!type_two)
              n.lsp[i] = r.pval[i]; // R12 R13 R15
          end
          if (cur == MODE_AUTO && nm == MODE_CASCADE && !type_two)
            n.cout[maj] = r.pval[i]; // R13 R14
          if (cur == MODE_CASCADE && nm != MODE_CASCADE
              && r.mode2[i][M2_MINOR])
          begin
            n.mode[maj] = MODE_MANUAL; // R10
            if (r.run_s2)
              n.desired[maj] = MODE_MANUAL; // R10
          end
          if (nm != MODE_MANUAL && !hold)
          begin
            if (nm == MODE_CASCADE)
              setp = tbl_word(r, maj, r.rsp[i][5:0]); // R19
            else
              setp = r.lsp[i]; // R19
            if (r.mode2[i][M2_SETPT_LIM])
              setp = clamp_setp(setp, r.splo[i], r.sphi[i], fmt); // R17 R18
            n.calc_out.valid = 1'b1;
            n.calc_out.loop = i;
            n.calc_out.fmt = fmt; // R16
            n.calc_out.setpoint = setp;
          end
        end
        if (i == 4'(NLOOPS - 1))
          n.st = PMS_IDLE;
        else
          n.idx = i + 4'h1;
      end
      default:
        n.st = PMS_IDLE;
    endcase

    // controller mode changes act on all following loops at once
    for (int j = 0; j < NLOOPS; j++)
    begin
      if (r.cfg[j] && !r.mode1[j][M1_INDEP])
      begin
        if (run_fall)
          n.mode[j] = MODE_MANUAL; // R01
        else if (run_rise)
          n.mode[j] = r.desired[j]; // R04
      end
      if (r.cfg[j] && pwr_rise && r.run_s2)
        n.mode[j] = r.desired[j]; // R03
    end

    // table port; a write lands after the request clear, so it wins
    if (tbl_req.wr && 32'(tbl_req.loop) < NLOOPS)
    begin
      if (!r.cfg[tbl_req.loop] && !r.run_s2)
      begin
        n.cfg[tbl_req.loop] = 1'b1; // R05
        n.mode[tbl_req.loop] = MODE_MANUAL; // R05
        n.desired[tbl_req.loop] = MODE_MANUAL; // R05
      end
      if (r.cfg[tbl_req.loop] || !r.run_s2)
      begin
        if (tbl_req.off == OFF_MODE_ONE)
          n.mode1[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_MODE_TWO)
          n.mode2[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_LOC_SETPT)
          n.lsp[tbl_req.loop] = tbl_req.wdata; // R17
        else if (tbl_req.off == OFF_PROC_VAL)
          n.pval[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_INTEG)
          n.integ[tbl_req.loop] = tbl_req.wdata; // R20
        else if (tbl_req.off == OFF_CTRL_OUT)
          n.cout[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_SETPT_LO)
          n.splo[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_SETPT_HI)
          n.sphi[tbl_req.loop] = tbl_req.wdata;
        else if (tbl_req.off == OFF_RSP_PTR)
          n.rsp[tbl_req.loop] = tbl_req.wdata;
      end
    end
    if (tbl_req.rd)
    begin
      n.rsp_out.rvalid = 1'b1;
      n.rsp_out.rdata = (32'(tbl_req.loop) < NLOOPS)
                        ? tbl_word(r, tbl_req.loop, tbl_req.off)
                        : WORD_RST;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      r <= '0;
    else
      r <= n;
  end

  assign tbl_rsp = r.rsp_out;
  assign calc = r.calc_out;
  assign run_active = r.run_s2;

endmodule : pms_loop_mode_supervisor

// ===== rtl/pms_pkg.sv
// package for the loop mode supervisor: table map, modes, carriers
package pms_pkg;

  // loop count and table geometry
  localparam int          PMS_MAX_LOOPS = 16;
  localparam int          PMS_IDXW      = 4;
  localparam int          PMS_OFFW      = 6;

  // loop parameter table word offsets
  localparam logic [5:0]  OFF_MODE_ONE  = 6'h00;
  localparam logic [5:0]  OFF_MODE_TWO  = 6'h01;
  localparam logic [5:0]  OFF_LOC_SETPT = 6'h02;
  localparam logic [5:0]  OFF_PROC_VAL  = 6'h03;
  localparam logic [5:0]  OFF_INTEG     = 6'h04;
  localparam logic [5:0]  OFF_CTRL_OUT  = 6'h05;
  localparam logic [5:0]  OFF_STATUS    = 6'h06;
  localparam logic [5:0]  OFF_SETPT_LO  = 6'h26;
  localparam logic [5:0]  OFF_SETPT_HI  = 6'h27;
  localparam logic [5:0]  OFF_RSP_PTR   = 6'h32;

  // first mode setting word fields
  localparam int          M1_XFER_TYPE  = 3;
  localparam int          M1_VELOCITY   = 5;
  localparam int          M1_INDEP      = 15;

  // second mode setting word fields
  localparam int          M2_FMT_WIDE   = 0;
  localparam int          M2_FMT_BIPOL  = 1;
  localparam int          M2_SETPT_LIM  = 3;
  localparam int          M2_MINOR      = 4;

  // remote setpoint pointer layout: loop index above word offset
  localparam int          PTR_LOOP_LSB  = 6;

  // one-hot loop modes, same coding as request and status bits
  localparam logic [2:0]  MODE_MANUAL   = 3'h1;
  localparam logic [2:0]  MODE_AUTO     = 3'h2;
  localparam logic [2:0]  MODE_CASCADE  = 3'h4;
  localparam logic [2:0]  REQ_NONE      = 3'h0;

  // reset values
  localparam logic [15:0] WORD_RST      = 16'h0000;

  typedef enum logic [0:0] {PMS_IDLE, PMS_SCAN} pms_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  loop;
    logic [5:0]  off;
    logic [15:0] wdata;
  } pms_tbl_req_t;

  typedef struct packed {
    logic        rvalid;
    logic [15:0] rdata;
  } pms_tbl_rsp_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  loop;
    logic [1:0]  fmt;
    logic [15:0] setpoint;
  } pms_calc_t;

endpackage : pms_pkg

// ===== dv/pms_checker.sv
// port checker for the loop mode supervisor
`timescale 1ns/1ps
module pms_checker
  import pms_pkg::*;
#(
  parameter int NLOOPS = 16
)
(
  // clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // table access
  input wire pms_pkg::pms_tbl_req_t tbl_req,
  input wire pms_pkg::pms_tbl_rsp_t tbl_rsp,
  // scan and pins
  input wire logic                  loop_tick,
  input wire logic [15:0]           loop_error,
  input wire logic                  run_mode_pin,
  input wire logic                  power_restored_pin,
  // calculation side
  input wire pms_pkg::pms_calc_t    calc,
  input wire logic                  run_active
);
  logic [4:0]  cnt_r;
  logic [15:0] err_r;
  logic [15:0] ind_r;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // scan position, error and independence shadows
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 5'h00;
      err_r <= 16'h0000;
      ind_r <= 16'h0000;
    end
    else
    begin
      err_r <= loop_error;
      if (cnt_r == 5'h00)
        cnt_r <= {4'h0, loop_tick};
      else if (int'(cnt_r) <= NLOOPS)
        cnt_r <= cnt_r + 5'h01;
      else
        cnt_r <= {4'h0, loop_tick};
      if (tbl_req.wr && tbl_req.off == OFF_MODE_ONE)
        ind_r[tbl_req.loop] <= tbl_req.wdata[M1_INDEP];
    end
  end

  a_read_answer: assert property (tbl_req.rd |=> tbl_rsp.rvalid)
    else $error("read answer missing");
  a_answer_cause: assert property (tbl_rsp.rvalid |-> $past(tbl_req.rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!tbl_rsp.rvalid |-> $stable(tbl_rsp.rdata))
    else $error("read data moved");
  a_status_onehot: assert property (tbl_rsp.rvalid &&
    $past(tbl_req.off) == OFF_STATUS |-> $onehot0(tbl_rsp.rdata[2:0]))
    else $error("status mode not one-hot");
  a_scan_order: assert property (calc.valid |-> cnt_r >= 5'h02 &&
    calc.loop == 4'(cnt_r - 5'h02))
    else $error("calculation out of scan order");
  a_error_manual: assert property (calc.valid |-> !err_r[calc.loop])
    else $error("calculation on loop in error");
  a_program_hold: assert property (calc.valid && !run_active &&
    !$past(run_active) && !$past(run_active, 2) |-> ind_r[calc.loop])
    else $error("following loop calculated in program");
  a_run_follow: assert property ($stable(run_mode_pin) [*4] |->
    run_active == run_mode_pin)
    else $error("run level not followed");

  c_calc: cover property (calc.valid);
  c_status: cover property (tbl_rsp.rvalid && $past(tbl_req.off) == OFF_STATUS);
  c_run: cover property ($rose(run_active));
endmodule : pms_checker

bind pms_loop_mode_supervisor pms_checker #(.NLOOPS(NLOOPS)) u_chk (
  .sys_clk(sys_clk),
  .rst(rst),
  .tbl_req(tbl_req),
  .tbl_rsp(tbl_rsp),
  .loop_tick(loop_tick),
  .loop_error(loop_error),
  .run_mode_pin(run_mode_pin),
  .power_restored_pin(power_restored_pin),
  .calc(calc),
  .run_active(run_active)
);

// ===== dv/tb.sv
// self-checking testbench for the loop mode supervisor
`timescale 1ns/1ps
module tb;
  import pms_pkg::*;
  localparam int NL = 4;
  logic         sys_clk = 1'b0;
  logic         rst = 1'b1;
  logic         loop_tick = 1'b0;
  logic         run_mode_pin = 1'b0;
  logic         power_restored_pin = 1'b0;
  logic [15:0]  loop_error = 16'h0000;
  logic         run_active;
  pms_tbl_req_t tbl_req = '0;
  pms_tbl_rsp_t tbl_rsp;
  pms_calc_t    calc;
  logic [15:0]  setp_seen [NL];
  logic [1:0]   fmt_seen [NL];
  logic [15:0]  rv;
  logic [15:0]  m;
  int           n_fail = 0;
  int           checked = 0;
  int           i;

  initial
    forever #2.5 sys_clk = ~sys_clk;

  pms_loop_mode_supervisor #(.NLOOPS(NL)) uut (
    .sys_clk(sys_clk),
    .rst(rst),
    .tbl_req(tbl_req),
    .tbl_rsp(tbl_rsp),
    .loop_tick(loop_tick),
    .loop_error(loop_error),
    .run_mode_pin(run_mode_pin),
    .power_restored_pin(power_restored_pin),
    .calc(calc),
    .run_active(run_active)
  );

  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic acc(bit w, int l, logic [5:0] o, logic [15:0] d);
    @(posedge sys_clk);
    #1;
    tbl_req = '{wr: w, rd: !w, loop: 4'(l), off: o, wdata: d};
    @(posedge sys_clk);
    #1;
    tbl_req.wr = 1'b0;
    tbl_req.rd = 1'b0;
    rv = (tbl_rsp.rvalid === 1'b1) ? tbl_rsp.rdata : 16'hXXXX;
  endtask : acc

  task automatic wr(int l, logic [5:0] o, logic [15:0] d);
    acc(1'b1, l, o, d);
  endtask : wr

  task automatic rd(int l, logic [5:0] o);
    acc(1'b0, l, o, 16'h0000);
  endtask : rd

  task automatic st(int l, logic [2:0] e);
    rd(l, OFF_STATUS);
    chk("mode", {13'h0000, e}, {13'h0000, rv[2:0]});
  endtask : st

  // one scan; remembers setpoint and format of each calculation
  task automatic tick();
    foreach (setp_seen[j])
      setp_seen[j] = 16'hXXXX;
    @(posedge sys_clk);
    #1;
    loop_tick = 1'b1;
    @(posedge sys_clk);
    #1;
    loop_tick = 1'b0;
    repeat (NL + 4)
    begin
      @(posedge sys_clk);
      #1;
      if (calc.valid === 1'b1)
      begin
        setp_seen[calc.loop] = calc.setpoint;
        fmt_seen[calc.loop] = calc.fmt;
      end
    end
  endtask : tick

  task automatic pause();
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : pause

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    #400000;
    n_fail++;
    $display("[ERR] watchdog exp end got hang");
    tally_and_finish();
  end

  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    // configure in program mode: loop1 independent, loop2 minor of loop3
    wr(0, OFF_MODE_ONE, 16'h0000);
    wr(1, OFF_MODE_ONE, 16'h8000);
    wr(2, OFF_MODE_TWO, 16'h0010);
    wr(2, OFF_RSP_PTR, 16'h00C5);
    wr(3, OFF_MODE_ONE, 16'h0000);
    for (i = 0; i < NL; i++)
      st(i, MODE_MANUAL);
    rd(5, OFF_MODE_ONE);
    chk("bad loop", 16'h0000, rv);
    $display("test config done");
    // transfer kinds; velocity only with type I
    for (i = 0; i < 3; i++)
    begin
      m = {8'h80, 2'b00, i[0], 1'b0, i[1], 3'b000};
      wr(1, OFF_MODE_ONE, m | 16'h0001);
      tick();
      wr(1, OFF_LOC_SETPT, 16'h0040);
      wr(1, OFF_PROC_VAL, 16'h0999);
      wr(1, OFF_CTRL_OUT, 16'h0055);
      wr(1, OFF_INTEG, 16'h0011);
      wr(1, OFF_MODE_ONE, m | 16'h0002);
      tick();
      st(1, MODE_AUTO);
      rd(1, OFF_MODE_ONE);
      chk("request", m, rv);
      rd(1, OFF_LOC_SETPT);
      chk("setpoint", i[1] ? 16'h0040 : 16'h0999, rv);
      rd(1, OFF_INTEG);
      chk("bias", i[0] ? 16'h0011 : 16'h0055, rv);
    end
    $display("test transfer done");
    // formats and clamping
    wr(1, OFF_SETPT_LO, 16'h0010);
    wr(1, OFF_SETPT_HI, 16'h0100);
    wr(1, OFF_LOC_SETPT, 16'h4700);
    for (i = 0; i < 4; i++)
    begin
      wr(1, OFF_MODE_TWO, {12'h000, 2'b10, i[1:0]});
      tick();
      chk("fmt", {14'h0000, i[1:0]}, {14'h0000, fmt_seen[1]});
      chk("clamp", (i == 3) ? 16'h0010 : 16'h0100, setp_seen[1]);
    end
    wr(1, OFF_SETPT_LO, 16'h0020);
    tick();
    chk("new limit", 16'h0020, setp_seen[1]);
    wr(1, OFF_MODE_TWO, 16'h0003);
    tick();
    chk("no clamp", 16'h4700, setp_seen[1]);
    $display("test setpoint done");
    // run mode requests and cascade pair
    run_mode_pin = 1'b1;
    pause();
    chk("run", 16'h0001, {15'h0000, run_active});
    wr(0, OFF_MODE_ONE, 16'h0004);
    tick();
    st(0, MODE_MANUAL);
    wr(0, OFF_MODE_ONE, 16'h0002);
    tick();
    st(0, MODE_AUTO);
    wr(0, OFF_MODE_ONE, 16'h0003);
    tick();
    st(0, MODE_AUTO);
    rd(0, OFF_MODE_ONE);
    chk("request", 16'h0000, rv);
    wr(3, OFF_MODE_ONE, 16'h0002);
    tick();
    st(3, MODE_MANUAL);
    wr(2, OFF_PROC_VAL, 16'h0321);
    wr(2, OFF_MODE_ONE, 16'h0002);
    tick();
    wr(2, OFF_MODE_ONE, 16'h0004);
    tick();
    st(2, MODE_CASCADE);
    rd(3, OFF_CTRL_OUT);
    chk("major out", 16'h0321, rv);
    wr(3, OFF_CTRL_OUT, 16'h0456);
    tick();
    chk("remote setpoint", 16'h0456, setp_seen[2]);
    wr(3, OFF_MODE_ONE, 16'h0002);
    tick();
    st(3, MODE_AUTO);
    loop_error = 16'h0004;
    tick();
    st(2, MODE_MANUAL);
    st(3, MODE_MANUAL);
    loop_error = 16'h0000;
    // program and back to run, then power restore
    run_mode_pin = 1'b0;
    pause();
    st(0, MODE_MANUAL);
    st(1, MODE_AUTO);
    wr(0, OFF_MODE_ONE, 16'h0002);
    tick();
    st(0, MODE_MANUAL);
    power_restored_pin = 1'b1;
    pause();
    power_restored_pin = 1'b0;
    pause();
    st(0, MODE_MANUAL);
    run_mode_pin = 1'b1;
    pause();
    st(0, MODE_AUTO);
    power_restored_pin = 1'b1;
    pause();
    power_restored_pin = 1'b0;
    pause();
    st(0, MODE_AUTO);
    st(2, MODE_MANUAL);
    $display("test modes done");
    tally_and_finish();
  end
endmodule : tb
